// ---- src/scan_sequencer.sv ----
// Purpose: automatic channel scan sequencer with timing and power control
// Assumes: tick_en pulses once per decimated clock period
// Notes: conversion engine is outside; conv_done ends one conversion
// Overview of operation
// R1 - absent channel enables ignore writes per variant
// R2 - supply channel forces 0x98, gain one third
// R3 - overrides never change stored registers
// R4 - thermal channel forces 0xDE, unity gain
// R5 - zero channel shorts mux to ground
// R6 - host writes negated offset into correction; this design has no correction store
// R7 - common-mode channel forces 0xF8, unity gain
// R8 - settle code lives in sequence bits 22:20
// R9 - code maps to 0,8,16..512 ticks
// R10 - settle only between conversions of cycle
// R11 - converter standby in settle, reads convert
// R12 - mux moves to next channel at done
// R13 - continuous cycles spaced by timer wait
// R14 - wait is 24-bit tick count
// R15 - counter loads wait, decrements, launches cycle
// R16 - long wait shuts converter down
// R17 - power up when counter reaches 256
// R18 - short wait holds converter in standby
// R19 - power field reads conversion code
// R20 - channels converted highest enable first
// R21 - repeat setting 11 loops, else once
// R22 - each conversion raises data ready
// R23 - wait equal to warm-up uses standby
`timescale 1ns/10ps
`default_nettype none
module scan_sequencer
	import scan_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick_en,
	input wire logic [1:0] variant,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [3:0] addr,
	input wire logic [23:0] wdata,
	input wire logic [1:0] pwr_req,
	input wire logic [1:0] repeat_setting,
	input wire logic [7:0] user_mux,
	input wire logic [2:0] user_gain,
	input wire logic conv_done,
	output logic [23:0] rdata,
	output logic [7:0] mux_sel,
	output logic [2:0] gain_sel,
	output logic temp_diodes_on,
	output logic short_to_ground,
	output logic [1:0] adc_power,
	output logic conv_start,
	output logic data_ready,
	output logic [3:0] chan_id,
	output logic busy
);
	typedef struct packed {
		logic [23:0] seq;
		logic [23:0] timer;
		seq_state_t st;
		logic [15:0] pending;
		logic [3:0] chan;
		logic [23:0] cnt;
		logic [23:0] rdata;
		logic [7:0] mux;
		logic [2:0] gain;
		logic temp;
		logic short;
		logic [1:0] power;
		logic start;
		logic ready;
		logic [3:0] chan_id;
		logic busy;
		logic done;
	} state_t;

	state_t r;
	state_t next_r;
	logic [9:0] settle_ticks;

	settle_lookup u_settle (
		.clk(clk),
		.rst_n(rst_n),
		.code(r.seq[SETTLE_MSB:SETTLE_LSB]),
		.ticks(settle_ticks)
	);

	// ==========================================
	// helpers
	function automatic logic [23:0] variant_mask(input logic [1:0] v);
		unique case (v)
			VARIANT_TWO: variant_mask = MASK_TWO;
			VARIANT_FOUR: variant_mask = MASK_FOUR;
			default: variant_mask = MASK_EIGHT;
		endcase
	endfunction

	// highest set bit of the pending set
	function automatic logic [4:0] top_channel(input logic [15:0] p);
		top_channel = 5'h10;
		for (int i = 0; i < 16; i++)
			if (p[i])
				top_channel = 5'(i);
	endfunction

	// mux code for a channel; overrides leave the registers untouched
	function automatic logic [7:0] chan_mux(input logic [3:0] c,
		input logic [7:0] um);
		if (c == CH_SUPPLY)
			chan_mux = MUX_SUPPLY; // [R2]
		else if (c == CH_TEMP)
			chan_mux = MUX_TEMP; // [R4]
		else if (c == CH_VCM)
			chan_mux = MUX_VCM; // [R7]
		else if (c == CH_ZERO)
			chan_mux = MUX_ZERO; // [R5]
		else if (c[3])
			chan_mux = {1'b0, c[1:0], 1'b0, 1'b0, c[1:0], 1'b1} + 8'h00;
		else
			chan_mux = {c, 4'h8};
		if (um == 8'h00 && c == 4'h0)
			chan_mux = 8'h08;
	endfunction

	function automatic logic [2:0] chan_gain(input logic [3:0] c,
		input logic [2:0] ug);
		if (c == CH_SUPPLY)
			chan_gain = GAIN_THIRD; // [R2]
		else if (c == CH_TEMP || c == CH_VCM)
			chan_gain = GAIN_UNITY; // [R4] [R7]
		else
			chan_gain = ug; // [R3]
	endfunction

	// ==========================================
	// next state
	logic [4:0] nxt;
	logic [15:0] rest;
	always_comb
	begin
		next_r = r;
		next_r.start = 1'b0;
		next_r.ready = 1'b0;
		rest = r.pending;
		rest[r.chan] = 1'b0;
		nxt = top_channel(rest); // [R20]
		if (wr_en && addr == SEQ_ADDR)
			next_r.seq = wdata & variant_mask(variant); // [R1] [R8]
		if (wr_en && addr == TIMER_ADDR)
			next_r.timer = wdata; // [R14]
		if (rd_en)
		begin
			if (addr == SEQ_ADDR)
				next_r.rdata = r.seq;
			else if (addr == TIMER_ADDR)
				next_r.rdata = r.timer;
			else if (addr == SETUP_ADDR)
				next_r.rdata = {22'h0,
					(r.busy ? PWR_CONVERT : r.power)}; // [R11] [R19]
			else
				next_r.rdata = 24'h000000;
		end
		unique case (r.st)
			S_IDLE:
			begin
				next_r.busy = 1'b0;
				next_r.power = r.done ? PWR_STANDBY : pwr_req;
				// a finished one-shot waits until the host rewrites the mode
				if (pwr_req != PWR_CONVERT)
					next_r.done = 1'b0; // [R21]
				if (!r.done && pwr_req == PWR_CONVERT
					&& r.seq[15:0] != 16'h0)
				begin
					next_r.pending = r.seq[15:0];
					next_r.chan = 4'(top_channel(r.seq[15:0])); // [R20]
					next_r.st = S_CONVERT;
					next_r.busy = 1'b1;
					next_r.start = 1'b1;
					next_r.power = PWR_CONVERT;
				end
			end
			S_CONVERT:
			begin
				next_r.mux = chan_mux(r.chan, user_mux);
				next_r.gain = chan_gain(r.chan, user_gain);
				next_r.temp = (r.chan == CH_TEMP); // [R4]
				next_r.short = (r.chan == CH_ZERO); // [R5]
				next_r.chan_id = r.chan;
				if (conv_done)
				begin
					next_r.ready = 1'b1; // [R22]
					next_r.pending = rest;
					if (nxt != 5'h10)
					begin
						next_r.chan = nxt[3:0];
						next_r.mux = chan_mux(nxt[3:0], user_mux); // [R12]
						next_r.cnt = {14'h0, settle_ticks};
						next_r.st = S_SETTLE; // [R10]
						next_r.power = PWR_STANDBY; // [R11]
					end
					else if (repeat_setting == REPEAT_CONT)
					begin
						next_r.cnt = r.timer; // [R13] [R15]
						next_r.st = S_WAIT;
						next_r.power = (r.timer > WARMUP_TICKS) ?
							PWR_OFF : PWR_STANDBY; // [R16] [R18] [R23]
					end
					else
					begin
						next_r.st = S_IDLE; // [R21]
						next_r.busy = 1'b0;
						next_r.power = PWR_STANDBY;
						next_r.done = 1'b1;
					end
				end
			end
			S_SETTLE:
			begin
				if (r.cnt == 24'h0)
				begin
					next_r.st = S_CONVERT;
					next_r.start = 1'b1;
					next_r.power = PWR_CONVERT;
				end
				else if (tick_en)
					next_r.cnt = r.cnt - 24'h1;
			end
			S_WAIT:
			begin
				if (r.cnt == 24'h0)
				begin
					next_r.pending = r.seq[15:0];
					next_r.chan = 4'(top_channel(r.seq[15:0]));
					next_r.st = (r.seq[15:0] == 16'h0) ? S_IDLE : S_CONVERT;
					next_r.start = (r.seq[15:0] != 16'h0); // [R15]
					next_r.power = PWR_CONVERT;
				end
				else if (tick_en)
				begin
					next_r.cnt = r.cnt - 24'h1; // [R15]
					if (r.cnt == WARMUP_TICKS + 24'h1 && r.power == PWR_OFF)
						next_r.power = PWR_STANDBY; // [R17]
				end
			end
			default:
				next_r.st = S_IDLE;
		endcase
		if (r.st != S_IDLE && pwr_req != PWR_CONVERT)
		begin
			next_r.st = S_IDLE;
			next_r.busy = 1'b0;
			next_r.power = pwr_req;
		end
	end

	// ==========================================
	// registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign rdata = r.rdata;
	assign mux_sel = r.mux;
	assign gain_sel = r.gain;
	assign temp_diodes_on = r.temp;
	assign short_to_ground = r.short;
	assign adc_power = r.power;
	assign conv_start = r.start;
	assign data_ready = r.ready;
	assign chan_id = r.chan_id;
	assign busy = r.busy;

	// ==========================================
	// checks
	supply_gain_a: assert property ( // [R2]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_CONVERT && r.chan == CH_SUPPLY
		|=> gain_sel == GAIN_THIRD)
		else $error("supply gain wrong");
	temp_diode_a: assert property ( // [R4]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_CONVERT && r.chan == CH_TEMP |=> temp_diodes_on)
		else $error("temp diodes off");
	settle_standby_a: assert property ( // [R11]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_SETTLE && pwr_req == PWR_CONVERT
		|-> adc_power == PWR_STANDBY)
		else $error("settle not standby");
	ready_pulse_a: assert property ( // [R22]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_CONVERT && conv_done && pwr_req == PWR_CONVERT
		|=> data_ready)
		else $error("no data ready");
	mode_read_a: assert property ( // [R19]
		@(posedge clk) disable iff (!rst_n)
		rd_en && addr == SETUP_ADDR && busy
		|=> rdata[1:0] == PWR_CONVERT)
		else $error("mode reads wrong");
	seq_mask_a: assert property ( // [R1]
		@(posedge clk) disable iff (!rst_n)
		wr_en && addr == SEQ_ADDR && variant == VARIANT_TWO
		|=> (r.seq & ~MASK_TWO) == 24'h000000)
		else $error("absent bits stored");
	wait_count_a: assert property ( // [R15]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_WAIT && tick_en && r.cnt != 24'h000000
		&& pwr_req == PWR_CONVERT
		|=> r.cnt == $past(r.cnt) - 24'h000001)
		else $error("wait count stuck");
	long_off_a: assert property ( // [R16]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_CONVERT && conv_done && nxt == 5'h10
		&& pwr_req == PWR_CONVERT && repeat_setting == REPEAT_CONT
		&& r.timer > WARMUP_TICKS |=> adc_power == PWR_OFF)
		else $error("no shutdown");
	oneshot_stop_a: assert property ( // [R21]
		@(posedge clk) disable iff (!rst_n)
		r.st == S_IDLE && r.done |=> !conv_start)
		else $error("one-shot scan restarted");
endmodule // scan_sequencer
`default_nettype wire

// ---- shared/scan_seq_pkg.sv ----
// Purpose: constants and types shared by the scan sequencer files
// Assumes: decimated clock tick arrives as an enable pulse
// Notes: values held here only
package scan_seq_pkg;
	localparam logic [3:0] TIMER_ADDR = 4'h8;
	localparam logic [3:0] SEQ_ADDR = 4'h7;
	localparam logic [3:0] SETUP_ADDR = 4'h1;
	localparam int SEQ_W = 24;
	localparam int TIMER_W = 24;
	localparam int SETTLE_LSB = 20;
	localparam int SETTLE_MSB = 22;
	localparam logic [23:0] WARMUP_TICKS = 24'h000100;
	localparam logic [1:0] PWR_OFF = 2'h0;
	localparam logic [1:0] PWR_STANDBY = 2'h2;
	localparam logic [1:0] PWR_CONVERT = 2'h3;
	localparam logic [1:0] REPEAT_CONT = 2'h3;
	localparam logic [7:0] MUX_VCM = 8'hF8;
	localparam logic [7:0] MUX_SUPPLY = 8'h98;
	localparam logic [7:0] MUX_TEMP = 8'hDE;
	localparam logic [7:0] MUX_ZERO = 8'h88;
	localparam logic [2:0] GAIN_THIRD = 3'h0;
	localparam logic [2:0] GAIN_UNITY = 3'h3;
	localparam logic [1:0] VARIANT_TWO = 2'h0;
	localparam logic [1:0] VARIANT_FOUR = 2'h1;
	localparam logic [1:0] VARIANT_EIGHT = 2'h2;
	localparam logic [23:0] MASK_TWO = 24'hF1F103;
	localparam logic [23:0] MASK_FOUR = 24'hF1F30F;
	localparam logic [23:0] MASK_EIGHT = 24'hF1FFFF;
	localparam logic [3:0] CH_ZERO = 4'hF;
	localparam logic [3:0] CH_VCM = 4'hE;
	localparam logic [3:0] CH_SUPPLY = 4'hD;
	localparam logic [3:0] CH_TEMP = 4'hC;
	typedef enum logic [2:0] {
		S_IDLE,
		S_CONVERT,
		S_SETTLE,
		S_WAIT
	} seq_state_t;
endpackage

// ---- src/settle_lookup.sv ----
// Purpose: settle delay code to tick count
// Assumes: code is three bits
// Notes: registered output
`timescale 1ns/10ps
`default_nettype none
module settle_lookup
	import scan_seq_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] code,
	output logic [9:0] ticks
);
	// ==========================================
	// lookup
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ticks <= 10'h000;
		else if (code == 3'h0)
			ticks <= 10'h000; // [R9]
		else
			ticks <= 10'(10'h004 << code); // [R9]
	end
endmodule // settle_lookup
`default_nettype wire

// ---- sim/conv_engine_model.sv ----
// Purpose: converter engine stand-in, answers conv_start with conv_done
// Assumes: one conversion in flight at a time
// Notes: slow picks a long conversion, otherwise a short one
`timescale 1ns/10ps
`default_nettype none
module conv_engine_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic slow,
	output logic conv_done
);
	int cnt;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			conv_done <= 1'b0;
		end
		else
		begin
			conv_done <= (cnt == 1);
			if (conv_start)
				cnt <= slow ? 20 : 3;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule // conv_engine_model
`default_nettype wire

// ---- sim/adc_scan_sequencer_timing_tb.sv ----
// Purpose: self-checking bench for the scan sequencer
// Assumes: tick_en high every cycle unless halved, one tick per clock
// Notes: gaps compared as differences, fixed latencies cancel out
`timescale 1ns/10ps
`default_nettype none
module adc_scan_sequencer_timing_tb
	import scan_seq_pkg::*;
;
	typedef struct {logic [23:0] seq; logic [7:0] mux; logic [2:0] gain;
		logic dio; logic sh; logic [3:0] ch;} row_t;
	logic clk, rst_n, tick_en, wr_en, rd_en, conv_done, slow;
	logic [1:0] variant, pwr_req, repeat_setting;
	logic [3:0] addr, chan_id;
	logic [23:0] wdata, rdata, d;
	logic [7:0] user_mux, mux_sel;
	logic [2:0] user_gain, gain_sel;
	logic temp_diodes_on, short_to_ground, conv_start, data_ready, busy;
	logic [1:0] adc_power;
	logic half = 1'b0;
	int fail_count = 0, n_compared = 0, cycles = 0, g, g0, n0, n2;
	row_t rows[4] = '{'{24'h008000, MUX_ZERO, 3'h5, 1'b0, 1'b1, CH_ZERO},
		'{24'h004000, MUX_VCM, GAIN_UNITY, 1'b0, 1'b0, CH_VCM},
		'{24'h002000, MUX_SUPPLY, GAIN_THIRD, 1'b0, 1'b0, CH_SUPPLY},
		'{24'h001000, MUX_TEMP, GAIN_UNITY, 1'b1, 1'b0, CH_TEMP}};
	logic [23:0] masks[3] = '{MASK_TWO, MASK_FOUR, MASK_EIGHT};
	logic [23:0] tv[3] = '{24'h00000A, 24'h000100, 24'h00012C};
	scan_sequencer u_dut (.clk(clk), .rst_n(rst_n), .tick_en(tick_en),
		.variant(variant), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .pwr_req(pwr_req), .repeat_setting(repeat_setting),
		.user_mux(user_mux), .user_gain(user_gain), .conv_done(conv_done),
		.rdata(rdata), .mux_sel(mux_sel), .gain_sel(gain_sel),
		.temp_diodes_on(temp_diodes_on), .short_to_ground(short_to_ground),
		.adc_power(adc_power), .conv_start(conv_start),
		.data_ready(data_ready), .chan_id(chan_id), .busy(busy));
	conv_engine_model u_conv (.clk(clk), .rst_n(rst_n),
		.conv_start(conv_start), .slow(slow), .conv_done(conv_done));
	// ==========================================
	// clock, watchdog and helpers
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// divider stand-in: halved rate exercises the tick enable
	always @(posedge clk)
		tick_en <= half ? ~tick_en : 1'b1;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			fail_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [23:0] v);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [23:0] v);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		@(posedge clk);
		v = rdata;
	endtask
	// pulses are read as the value held before each edge
	task automatic wait_hi(input bit rdy);
		do @(posedge clk);
		while ((rdy ? data_ready : conv_start) !== 1'b1);
	endtask
	task automatic gap(output int gl, output int off, output int stby);
		gl = 0;
		off = 0;
		stby = 0;
		do
		begin
			@(posedge clk);
			gl++;
			off += (adc_power === PWR_OFF);
			stby += (adc_power === PWR_STANDBY);
		end
		while (conv_start !== 1'b1);
	endtask
	task automatic stop();
		pwr_req <= PWR_OFF;
		do @(posedge clk);
		while (busy !== 1'b0);
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		{rst_n, wr_en, rd_en, addr, wdata, repeat_setting} = '0;
		{slow, variant, pwr_req} = {1'b1, VARIANT_EIGHT, PWR_OFF};
		user_mux = 8'h5A;
		user_gain = 3'h5;
		repeat (6) @(posedge clk);
		chk({busy, adc_power, conv_start, data_ready, mux_sel}, 24'h0);
		rst_n <= 1'b1;
		for (int v = 0; v < 3; v++)
		begin
			variant <= v[1:0];
			wr(SEQ_ADDR, 24'hFFFFFF);
			rd(SEQ_ADDR, d);
			chk(d, masks[v]);
		end
		rd(4'h3, d);
		// no correction store here: the host keeps the offset itself
		chk(d, 24'h0);
		foreach (rows[i])
		begin
			wr(SEQ_ADDR, rows[i].seq);
			pwr_req <= PWR_CONVERT;
			wait_hi(0);
			repeat (2) @(posedge clk);
			chk(mux_sel, rows[i].mux);
			chk(gain_sel, rows[i].gain);
			chk({temp_diodes_on, short_to_ground}, {rows[i].dio, rows[i].sh});
			chk(chan_id, rows[i].ch);
			rd(SETUP_ADDR, d);
			chk(d[1:0], PWR_CONVERT);
			wait_hi(1);
			stop();
			rd(SEQ_ADDR, d);
			chk(d, rows[i].seq);
		end
		for (int c = 0; c < 8; c++)
		begin
			wr(SEQ_ADDR, {1'b0, c[2:0], 20'h03000});
			pwr_req <= PWR_CONVERT;
			wait_hi(0);
			repeat (2) @(posedge clk);
			chk(chan_id, CH_SUPPLY);
			wait_hi(1);
			chk(mux_sel, MUX_TEMP);
			gap(g, n0, n2);
			if (c == 0)
				g0 = g;
			chk(g - g0, (c == 0) ? 0 : 8 << (c - 1));
			chk(n2 >= g - g0, 1'b1);
			wait_hi(1);
			stop();
		end
		// halved tick rate stretches a 32-tick settle to 63 or 64 clocks
		half <= 1'b1;
		wr(SEQ_ADDR, 24'h303000);
		pwr_req <= PWR_CONVERT;
		wait_hi(1);
		gap(g, n0, n2);
		chk(g - g0 >= 63 && g - g0 <= 64, 1'b1);
		wait_hi(1);
		stop();
		half <= 1'b0;
		// ==========================================
		// continuous cycles, short, equal and long waits
		slow <= 1'b0;
		repeat_setting <= REPEAT_CONT;
		foreach (tv[k])
		begin
			wr(TIMER_ADDR, tv[k]);
			wr(SEQ_ADDR, 24'h002000);
			pwr_req <= PWR_CONVERT;
			wait_hi(1);
			gap(g, n0, n2);
			// g0 still holds the zero-delay gap of the settle sweep
			chk(g - g0, tv[k]);
			if (k < 2)
				chk(n0, 0);
			else
				chk(n0 > 40 && n0 < 48 && n2 > 250 && n2 < 262, 1'b1);
			stop();
		end
		end_sim();
	end
endmodule // adc_scan_sequencer_timing_tb
`default_nettype wire
